// File: core/ppc_defines.vh
// constants for the parallel port control block
// What this block does
// (RULE_01) port enable off means no off-chip access
// (RULE_02) idle-stop set halts port during idle
// (RULE_03) mux 11: low address byte on data
// (RULE_04) mux 10: full address on data pins
// (RULE_05) mux 01: low byte muxed, upper on lines
// (RULE_06) mux 00: separate address and data pins
// (RULE_07) write strobe pin enable gates pin drive
// (RULE_08) read strobe pin enable gates pin drive
// (RULE_09) chip select function: cs or address 14
// (RULE_10) latch polarity sets both latch strobes
// (RULE_11) polarities ignored on address-line pins
// (RULE_12) data path is one byte wide
// (RULE_13) eleven address lines with chip select
// (RULE_14) twelve address lines without chip select
// (RULE_15) separate strobes or direction plus enable
// (RULE_16) slave four-byte buffer, auto-incrementing index
// (RULE_17) upper sixteen control bits read zero
// (RULE_18) mode field selects master or slave kind
// (RULE_19) write polarity sets enable strobe in mode 11
// (RULE_20) disabled port holds controls inactive
// (RULE_21) control fields reset to zero
`ifndef PPC_DEFINES_VH
`define PPC_DEFINES_VH
// ==============================
// register byte offsets
`define PPC_OFF_CTRL    8'h00
`define PPC_OFF_MODE    8'h04
`define PPC_OFF_ADDR    8'h08
`define PPC_OFF_DATA    8'h0c
`define PPC_OFF_STAT    8'h10
`define PPC_OFF_SOUT    8'h14
`define PPC_OFF_SIN     8'h18
// ==============================
// control field positions
`define PPC_B_ON        15
`define PPC_B_IDLE_STOP      13
`define PPC_B_MUXH      12
`define PPC_B_MUXL      11
`define PPC_B_TTL       10
`define PPC_B_WREN      9
`define PPC_B_RDEN      8
`define PPC_B_CSFH      7
`define PPC_B_CSFL      6
`define PPC_B_ALP       5
`define PPC_B_CSP       3
`define PPC_B_WRITE_STROBE_POLARITY      1
`define PPC_B_READ_STROBE_POLARITY      0
`define PPC_CTRL_MASK   16'hbfeb
// ==============================
// encodings and reset values
`define PPC_MUX_SEP     2'h0
`define PPC_MUX_LO      2'h1
`define PPC_MUX_FULL    2'h2
`define PPC_MUX_LO8     2'h3
`define PPC_CSF_CS      2'h2
`define PPC_MODE_LEG    2'h0
`define PPC_MODE_ENH    2'h1
`define PPC_MODE_M2     2'h2
`define PPC_MODE_M1     2'h3
`define PPC_RST_CTRL    16'h0000
`define PPC_RST_MODE    6'h00
`endif

// File: core/ppc_port.v
// parallel port control: apb registers, master cycles, byte slave buffer
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/100ps
`include "ppc_defines.vh"
module ppc_port (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        idle_mode,
  input  wire [7:0]  port_data_in,
  output reg  [7:0]  port_data_out,
  output reg         port_data_oe,
  input  wire [1:0]  port_addr_in,
  output reg  [10:0] port_addr_bus,
  output reg         port_addr_oe,
  input  wire        chip_sel_in,
  output reg         chip_sel_out,
  output reg         chip_sel_oe,
  input  wire        read_strobe_in,
  output reg         read_strobe_out,
  output reg         read_strobe_oe,
  input  wire        write_strobe_in,
  output reg         write_strobe_out,
  output reg         write_strobe_oe,
  output reg         addr_latch_low,
  output reg         addr_latch_high,
  output reg         input_level_sel
);
  // ==============================
  // master cycle states
  localparam ST_IDLE = 3'h0;
  localparam ST_ALO  = 3'h1;
  localparam ST_AHI  = 3'h2;
  localparam ST_STRB = 3'h3;
  localparam ST_HOLD = 3'h4;

  reg  [15:0] port_control_reg;       // control register
  reg  [5:0]  mode_reg;               // mode[5:4], strobe wait [3:0]
  reg  [15:0] addr_reg;               // master address
  reg  [7:0]  wdata_reg;              // byte to write
  reg  [7:0]  rdata_reg;              // byte last read
  reg  [2:0]  state_reg;              // master state
  reg  [2:0]  state_next;
  reg  [3:0]  wait_reg;               // strobe length counter
  reg         dir_rd_reg;             // current cycle is a read
  reg  [31:0] sout_reg;               // bytes for the external master
  reg  [31:0] sin_reg;                // bytes from the external master
  reg  [1:0]  idx_reg;                // slave buffer index
  reg  [12:0] s1_reg;                 // synchroniser first stage
  reg  [12:0] s2_reg;                 // synchroniser second stage
  reg  [12:0] s3_reg;                 // delayed second stage
  reg         start_wr;
  reg         start_rd;

  // control field views
  wire       ctl_on   = port_control_reg[`PPC_B_ON];
  wire       ctl_idle_stop = port_control_reg[`PPC_B_IDLE_STOP];
  wire [1:0] ctl_mux  = port_control_reg[`PPC_B_MUXH:`PPC_B_MUXL];
  wire       ctl_wren = port_control_reg[`PPC_B_WREN];
  wire       ctl_rden = port_control_reg[`PPC_B_RDEN];
  wire [1:0] ctl_csf  = port_control_reg[`PPC_B_CSFH:`PPC_B_CSFL];
  wire       ctl_alp  = port_control_reg[`PPC_B_ALP];
  wire       ctl_csp  = port_control_reg[`PPC_B_CSP];
  wire       ctl_write_strobe_polarity = port_control_reg[`PPC_B_WRITE_STROBE_POLARITY];
  wire       ctl_read_strobe_polarity = port_control_reg[`PPC_B_READ_STROBE_POLARITY];
  wire [1:0] mode     = mode_reg[5:4];
  wire       master   = mode[1];

  // halted while disabled, or idle with idle-stop set
  wire run = ctl_on & ~(ctl_idle_stop & idle_mode); // RULE_01 RULE_02
  wire busy = (state_reg != ST_IDLE);

  // ==============================
  // apb slave
  wire setup  = psel & ~penable;
  wire commit = psel & penable & pready & ~pslverr;
  wire wr_go  = commit & pwrite;
  reg  [31:0] rd_mux;
  reg         addr_ok;

  // read data and decode
  always @* begin
    rd_mux  = 32'h0000_0000;
    addr_ok = 1'b1;
    case (paddr)
      `PPC_OFF_CTRL: rd_mux = {16'h0000, port_control_reg}; // RULE_17
      `PPC_OFF_MODE: rd_mux = {22'h000000, mode_reg[5:4], 2'h0, mode_reg[3:0], 2'h0};
      `PPC_OFF_ADDR: rd_mux = {16'h0000, addr_reg};
      `PPC_OFF_DATA: rd_mux = {24'h000000, rdata_reg};
      `PPC_OFF_STAT: rd_mux = {24'h000000, idx_reg, 5'h00, busy};
      `PPC_OFF_SOUT: rd_mux = sout_reg;
      `PPC_OFF_SIN:  rd_mux = sin_reg;
      default:       addr_ok = 1'b0;    // unmapped answers error
    endcase
  end

  // one-cycle answer in access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~addr_ok;
      if (setup & ~pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // software register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_control_reg <= `PPC_RST_CTRL;  // RULE_21
      mode_reg         <= `PPC_RST_MODE;
      addr_reg         <= 16'h0000;
      wdata_reg        <= 8'h00;
      sout_reg         <= 32'h0000_0000;
      start_wr         <= 1'b0;
      start_rd         <= 1'b0;
    end else begin
      start_wr <= 1'b0;
      start_rd <= 1'b0;
      if (wr_go) begin
        case (paddr)
          `PPC_OFF_CTRL: port_control_reg <= pwdata[15:0] & `PPC_CTRL_MASK;
          `PPC_OFF_MODE: mode_reg <= {pwdata[9:8], pwdata[5:2]}; // RULE_18
          `PPC_OFF_ADDR: addr_reg <= pwdata[15:0];
          `PPC_OFF_DATA: begin
            wdata_reg <= pwdata[7:0];     // RULE_12
            start_wr  <= 1'b1;
          end
          `PPC_OFF_STAT: start_rd <= pwdata[1];
          `PPC_OFF_SOUT: sout_reg <= pwdata;
          default: ;                        // read-only or unmapped
        endcase
      end
    end
  end

  // ==============================
  // master cycle sequencer
  wire go = run & master & ~busy & (start_wr | start_rd);
  // next state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (go) begin
          state_next = (ctl_mux == `PPC_MUX_SEP) ? ST_STRB : ST_ALO; // RULE_06
        end
      end
      ST_ALO:  state_next = (ctl_mux == `PPC_MUX_FULL) ? ST_AHI : ST_STRB; // RULE_03 RULE_04
      ST_AHI:  state_next = ST_STRB;
      ST_STRB: state_next = (wait_reg == mode_reg[3:0]) ? ST_HOLD : ST_STRB;
      ST_HOLD: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // state, wait count, direction and read capture
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg  <= ST_IDLE;
      wait_reg   <= 4'h0;
      dir_rd_reg <= 1'b0;
      rdata_reg  <= 8'h00;
    end else if (!ctl_on) begin
      state_reg <= ST_IDLE;                 // RULE_01
      wait_reg  <= 4'h0;
    end else if (run) begin                 // RULE_02
      state_reg <= state_next;
      wait_reg  <= (state_reg == ST_STRB) ? wait_reg + 4'h1 : 4'h0; // strobe cycles so far
      if (go) begin
        dir_rd_reg <= start_rd;
      end
      if (state_reg == ST_STRB && state_next == ST_HOLD && dir_rd_reg) begin
        rdata_reg <= s2_reg[7:0];
      end
    end
  end

  // ==============================
  // pin synchronisers and slave buffer
  // bit map: data 7:0, addr 9:8, cs 10, rd 11, wr 12
  wire [12:0] pins_raw = {write_strobe_in, read_strobe_in, chip_sel_in,
                          port_addr_in, port_data_in};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= 13'h0000;
      s2_reg <= 13'h0000;
      s3_reg <= 13'h0000;
    end else begin
      s1_reg <= pins_raw;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // slave strobe views after sync
  wire cs_act  = (s2_reg[10] == ctl_csp);
  wire rd_act  = (s2_reg[11] == ctl_read_strobe_polarity) & cs_act;
  wire wr_act  = (s2_reg[12] == ctl_write_strobe_polarity) & cs_act;
  wire rd_prev = (s3_reg[11] == ctl_read_strobe_polarity) & (s3_reg[10] == ctl_csp);
  wire wr_prev = (s3_reg[12] == ctl_write_strobe_polarity) & (s3_reg[10] == ctl_csp);
  wire slave   = run & ~master;
  wire wr_end  = slave & wr_prev & ~wr_act;
  wire rd_end  = slave & rd_prev & ~rd_act;
  wire [1:0] sidx = (mode == `PPC_MODE_ENH) ? s3_reg[9:8] : idx_reg;

  // buffer index: addressed or auto-increment
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_reg <= 2'h0;
    end else if (!slave) begin
      idx_reg <= 2'h0;
    end else if (wr_end | rd_end) begin
      idx_reg <= sidx + 2'h1;               // RULE_16
    end
  end

  // received bytes, one slot per entry
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sin
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sin_reg[8*gi+7:8*gi] <= 8'h00;
        end else if (wr_end && sidx == gi) begin
          sin_reg[8*gi+7:8*gi] <= s3_reg[7:0]; // RULE_16
        end
      end
    end
  endgenerate

  wire [7:0] sout_byte = sout_reg[8*sidx +: 8];
  // ==============================
  // pin drive
  wire in_cycle = busy & run;
  wire st_alo   = in_cycle & (state_reg == ST_ALO);
  wire st_ahi   = in_cycle & (state_reg == ST_AHI);
  wire st_strb  = in_cycle & (state_reg == ST_STRB);
  wire cs_is_cs = (ctl_csf == `PPC_CSF_CS); // RULE_09
  wire m_drive  = run & master;
  reg  [7:0]  d_n;
  reg         doe_n;
  reg  [10:0] a_n;
  reg         cs_n;
  reg         rs_n;
  reg         ws_n;

  // next pin values, registered below
  always @* begin
    d_n   = 8'h00;
    doe_n = 1'b0;
    a_n   = 11'h000;
    cs_n  = ~ctl_csp;                       // RULE_20
    if (m_drive) begin
      case (ctl_mux)
        `PPC_MUX_SEP: a_n = addr_reg[10:0]; // RULE_06 RULE_13
        `PPC_MUX_LO:  a_n = {addr_reg[10:8], 8'h00}; // RULE_05
        default:      a_n = 11'h000;        // RULE_03 RULE_04
      endcase
      if (cs_is_cs) begin
        cs_n = in_cycle ? ctl_csp : ~ctl_csp;
      end else if (ctl_mux == `PPC_MUX_SEP || ctl_mux == `PPC_MUX_LO) begin
        cs_n = addr_reg[14];                // RULE_11 RULE_14
      end else begin
        cs_n = 1'b0;
      end
      if (st_alo) begin
        d_n   = addr_reg[7:0];
        doe_n = 1'b1;
      end else if (st_ahi) begin
        d_n   = addr_reg[15:8];
        doe_n = 1'b1;
      end else if (st_strb & ~dir_rd_reg) begin
        d_n   = wdata_reg;                  // RULE_12
        doe_n = 1'b1;
      end
    end else if (slave & rd_act) begin
      d_n   = sout_byte;                    // RULE_16
      doe_n = 1'b1;
    end
    // strobes: idle at inactive level
    rs_n = ~ctl_read_strobe_polarity;                       // RULE_20
    ws_n = ~ctl_write_strobe_polarity;
    if (m_drive & (mode == `PPC_MODE_M1)) begin
      rs_n = (in_cycle & dir_rd_reg) ? ctl_read_strobe_polarity : ~ctl_read_strobe_polarity; // RULE_15
      ws_n = st_strb ? ctl_write_strobe_polarity : ~ctl_write_strobe_polarity; // RULE_19
    end else if (m_drive) begin
      rs_n = (st_strb & dir_rd_reg) ? ctl_read_strobe_polarity : ~ctl_read_strobe_polarity; // RULE_15
      ws_n = (st_strb & ~dir_rd_reg) ? ctl_write_strobe_polarity : ~ctl_write_strobe_polarity; // RULE_19
    end
  end

  // registered pins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_data_out    <= 8'h00;
      port_data_oe     <= 1'b0;
      port_addr_bus    <= 11'h000;
      port_addr_oe     <= 1'b0;
      chip_sel_out     <= 1'b1;
      chip_sel_oe      <= 1'b0;
      read_strobe_out  <= 1'b1;
      read_strobe_oe   <= 1'b0;
      write_strobe_out <= 1'b1;
      write_strobe_oe  <= 1'b0;
      addr_latch_low   <= 1'b1;
      addr_latch_high  <= 1'b1;
      input_level_sel  <= 1'b0;
    end else begin
      port_data_out    <= d_n;
      port_data_oe     <= doe_n;            // RULE_01
      port_addr_bus    <= a_n;
      port_addr_oe     <= m_drive;
      chip_sel_out     <= cs_n;
      chip_sel_oe      <= m_drive;
      read_strobe_out  <= rs_n;
      read_strobe_oe   <= m_drive & ctl_rden; // RULE_08
      write_strobe_out <= ws_n;
      write_strobe_oe  <= m_drive & ctl_wren; // RULE_07
      addr_latch_low   <= st_alo ? ctl_alp : ~ctl_alp; // RULE_10
      addr_latch_high  <= st_ahi ? ctl_alp : ~ctl_alp; // RULE_10
      input_level_sel  <= port_control_reg[`PPC_B_TTL];
    end
  end
endmodule

// File: dv/ppc_port_monitor.sv
// assertion checker for the parallel port control block
`timescale 1ns/100ps
module ppc_port_monitor (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic        port_data_oe,
  input logic        port_addr_oe,
  input logic        read_strobe_oe,
  input logic        write_strobe_oe,
  input logic        addr_latch_low,
  input logic        addr_latch_high
);
  // ==========
  // control shadow
  logic [15:0] ctrl_reg;  // last control word written
  logic [15:0] ctrl_d_reg; // one cycle older copy
  wire         settled = (ctrl_reg == ctrl_d_reg); // pins lag one cycle
  wire         off     = !ctrl_reg[15];
  wire         idle_lv = !ctrl_reg[5]; // inactive latch level
  // shadow follows committed writes to offset zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg   <= 16'h0000;
      ctrl_d_reg <= 16'h0000;
    end else begin
      ctrl_d_reg <= ctrl_reg;
      if (psel && penable && pready && pwrite && paddr == 8'h00 && !pslverr) begin
        ctrl_reg <= pwdata[15:0] & 16'hbfeb;
      end
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========
  // bus handshake
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  property p_answer;
    s_setup |=> s_answer;
  endproperty
  property p_unmapped;
    psel && !penable && paddr > 8'h18 |=> pready && pslverr;
  endproperty
  property p_upper_zero;
    pready && !pwrite && paddr == 8'h00 |-> prdata[31:16] == 16'h0000;
  endproperty
  // ==========
  // pin behaviour
  property p_off_quiet;
    settled && off |-> !(port_data_oe || port_addr_oe || read_strobe_oe || write_strobe_oe);
  endproperty
  property p_wr_pin;
    settled && !ctrl_reg[9] |-> !write_strobe_oe;
  endproperty
  property p_rd_pin;
    settled && !ctrl_reg[8] |-> !read_strobe_oe;
  endproperty
  property p_latch_rest;
    settled && (off || ctrl_reg[12:11] == 2'h0)
      |-> addr_latch_low == idle_lv && addr_latch_high == idle_lv;
  endproperty
  property p_no_high;
    settled && ctrl_reg[11] |-> addr_latch_high == idle_lv;
  endproperty
  property p_latch_excl;
    settled |-> !(addr_latch_low != idle_lv && addr_latch_high != idle_lv);
  endproperty
  a_answer: assert property (p_answer)
    else $error("no single cycle answer");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper control bits not zero");
  a_off_quiet: assert property (p_off_quiet)
    else $error("disabled port drives pins");
  a_wr_pin: assert property (p_wr_pin)
    else $error("write strobe driven while pin off");
  a_rd_pin: assert property (p_rd_pin)
    else $error("read strobe driven while pin off");
  a_latch_rest: assert property (p_latch_rest)
    else $error("latch strobe active when it must rest");
  a_no_high: assert property (p_no_high)
    else $error("high latch used in low byte mode");
  a_latch_excl: assert property (p_latch_excl)
    else $error("both latches active together");
endmodule
bind ppc_port ppc_port_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .port_data_oe(port_data_oe), .port_addr_oe(port_addr_oe),
  .read_strobe_oe(read_strobe_oe), .write_strobe_oe(write_strobe_oe),
  .addr_latch_low(addr_latch_low), .addr_latch_high(addr_latch_high)
);

// File: dv/ppc_periph_model.sv
// byte device standing on the far side of the parallel port
`timescale 1ns/100ps
module ppc_periph_model (
  input  logic       pclk,
  input  logic [7:0] port_data_out,
  input  logic       port_data_oe,
  input  logic       read_strobe_out,
  input  logic       read_strobe_oe,
  input  logic       write_strobe_out,
  input  logic       write_strobe_oe,
  input  logic       addr_latch_low,
  input  logic       addr_latch_high,
  input  logic       latch_act,
  input  logic [7:0] rd_val,
  output logic [7:0] port_data_in,
  output logic [7:0] lo_seen,
  output logic [7:0] hi_seen,
  output logic [7:0] wr_seen,
  output logic [7:0] wr_count
);
  logic rd_act;  // read strobe active, low level
  logic wr_act;  // write strobe active, low level
  logic wr_prev; // write strobe one cycle ago
  assign rd_act = read_strobe_oe && !read_strobe_out;
  assign wr_act = write_strobe_oe && !write_strobe_out;
  // released bus shows the inverse, never a stale byte
  assign port_data_in = rd_act ? rd_val : ~rd_val;
  initial begin
    lo_seen  = 8'h00;
    hi_seen  = 8'h00;
    wr_seen  = 8'h00;
    wr_count = 8'h00;
    wr_prev  = 1'b0;
  end
  // latch address phases and count write strobes
  always @(posedge pclk) begin
    // a latch only takes a byte that the port is driving
    if (port_data_oe && addr_latch_low == latch_act) begin
      lo_seen <= port_data_out;
    end
    if (port_data_oe && addr_latch_high == latch_act) begin
      hi_seen <= port_data_out;
    end
    if (wr_act) begin
      wr_seen <= port_data_out;
    end
    if (wr_act && !wr_prev) begin
      wr_count <= wr_count + 8'h01;
    end
    wr_prev <= wr_act;
  end
endmodule

// File: dv/parallel_port_control_test.sv
// self-checking bench for the parallel port control block
`timescale 1ns/100ps
module parallel_port_control_test;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic idle_mode = 1'b0, latch_act = 1'b0, ext_cs = 1'b1, ext_wr = 1'b1, e;
  logic [7:0] paddr = 8'h00, rd_val = 8'h00, c0, port_data_in, port_data_out;
  logic [7:0] lo_seen, hi_seen, wr_seen, wr_count;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, port_data_oe, port_addr_oe, chip_sel_out, chip_sel_oe;
  logic read_strobe_out, read_strobe_oe, write_strobe_out, write_strobe_oe;
  logic addr_latch_low, addr_latch_high, input_level_sel;
  logic [10:0] port_addr_bus;
  logic [1:0] mx [3] = '{2'h3, 2'h1, 2'h0}; // mux codes to visit
  int mismatches = 0, checks_done = 0, cycles = 0;
  ppc_port u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .idle_mode(idle_mode), .port_data_in(port_data_in), .port_data_out(port_data_out),
    .port_data_oe(port_data_oe), .port_addr_in(2'h0), .port_addr_bus(port_addr_bus),
    .port_addr_oe(port_addr_oe), .chip_sel_in(ext_cs), .chip_sel_out(chip_sel_out),
    .chip_sel_oe(chip_sel_oe), .read_strobe_in(1'b1), .read_strobe_out(read_strobe_out),
    .read_strobe_oe(read_strobe_oe), .write_strobe_in(ext_wr),
    .write_strobe_out(write_strobe_out), .write_strobe_oe(write_strobe_oe),
    .addr_latch_low(addr_latch_low), .addr_latch_high(addr_latch_high),
    .input_level_sel(input_level_sel));
  ppc_periph_model u_dev (
    .pclk(pclk), .port_data_out(port_data_out), .port_data_oe(port_data_oe),
    .read_strobe_out(read_strobe_out),
    .read_strobe_oe(read_strobe_oe), .write_strobe_out(write_strobe_out),
    .write_strobe_oe(write_strobe_oe), .addr_latch_low(addr_latch_low),
    .addr_latch_high(addr_latch_high), .latch_act(latch_act), .rd_val(rd_val),
    .port_data_in(port_data_in), .lo_seen(lo_seen), .hi_seen(hi_seen),
    .wr_seen(wr_seen), .wr_count(wr_count));
  // ==========
  // clock, timeout and helpers
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end
  task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer; result left in q and e
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // poll busy until the port cycle ends
  task wait_idle;
    int n;
    n = 0;
    repeat (3) @(posedge pclk);
    apb(1'b0, 8'h10, 32'h0);
    while (q[0] !== 1'b0 && n < 100) begin
      n++;
      apb(1'b0, 8'h10, 32'h0);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ==========
  // tests
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    check("ctrl reset", q, 32'h0);
    check("oe reset", {26'h0, input_level_sel, chip_sel_oe, port_addr_oe, port_data_oe,
                       read_strobe_oe, write_strobe_oe}, 32'h0);
    apb(1'b1, 8'h00, 32'hffffffff);
    apb(1'b0, 8'h00, 32'h0);
    check("ctrl mask", q, 32'h0000bfeb);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped", {31'h0, e}, 32'h1);
    $display("test registers done");
    apb(1'b1, 8'h04, 32'h0000020c);
    apb(1'b1, 8'h08, 32'h00001234);
    for (int i = 0; i < 2; i++) begin
      latch_act <= i[0];
      rd_val <= 8'h5a ^ i[7:0];
      apb(1'b1, 8'h00, 32'h00009380 | {26'h0, i[0], 5'h0});
      apb(1'b1, 8'h0c, 32'h000000a5 ^ i);
      wait_idle();
      check("addr low", {24'h0, lo_seen}, 32'h34);
      check("addr high", {24'h0, hi_seen}, 32'h12);
      check("write byte", {24'h0, wr_seen}, 32'ha5 ^ i);
      apb(1'b1, 8'h10, 32'h2);
      wait_idle();
      apb(1'b0, 8'h0c, 32'h0);
      check("read byte", q, 32'h5a ^ i);
    end
    latch_act <= 1'b0;
    $display("test master transfers done");
    apb(1'b1, 8'h00, 32'h00001380);
    c0 = wr_count;
    apb(1'b1, 8'h0c, 32'h000000c3);
    repeat (20) @(posedge pclk);
    check("off writes", {24'h0, wr_count}, {24'h0, c0});
    apb(1'b1, 8'h00, 32'h0000b380);
    apb(1'b1, 8'h0c, 32'h00000077);
    @(posedge pclk);
    idle_mode <= 1'b1;            // cycle has just started, freeze it
    repeat (30) @(posedge pclk);
    check("idle frozen", {24'h0, wr_count}, {24'h0, c0});
    apb(1'b0, 8'h10, 32'h0);
    check("idle busy", {31'h0, q[0]}, 32'h1);
    idle_mode <= 1'b0;
    wait_idle();
    check("idle resumed", {24'h0, wr_count}, {24'h0, c0 + 8'h01});
    check("idle byte", {24'h0, wr_seen}, 32'h77);
    $display("test enable and idle done");
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 8'h08, 32'h00001200 | {30'h0, mx[i]});
      apb(1'b1, 8'h00, 32'h00008380 | {19'h0, mx[i], 11'h0});
      apb(1'b1, 8'h0c, {28'h1, 2'h0, mx[i]});
      wait_idle();
      check("mux low", {24'h0, lo_seen}, (mx[i] == 2'h0) ? 32'h1 : {30'h0, mx[i]});
      check("mux high", {24'h0, hi_seen}, 32'h12);
      check("mux byte", {24'h0, wr_seen}, {28'h1, 2'h0, mx[i]});
      check("mux lines", {21'h0, port_addr_bus}, mx[i][1] ? 32'h0 : 32'h200);
    end
    $display("test mux modes done");
    check("cs idle", {30'h0, chip_sel_oe, chip_sel_out}, 32'h3);
    apb(1'b1, 8'h04, 32'h0000030c);
    apb(1'b1, 8'h00, 32'h00008300);
    repeat (2) @(posedge pclk);
    check("cs as a14", {30'h0, chip_sel_oe, chip_sel_out}, 32'h2);
    apb(1'b1, 8'h0c, 32'h0000003c);
    wait_idle();
    check("enable strobe byte", {24'h0, wr_seen}, 32'h3c);
    $display("test strobe scheme done");
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h04, 32'h0);
    rd_val <= 8'h96;              // released bus then reads 0x69
    apb(1'b1, 8'h00, 32'h00008000);
    ext_cs <= 1'b0;
    ext_wr <= 1'b0;
    repeat (4) @(posedge pclk);
    ext_cs <= 1'b1;
    ext_wr <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, 8'h18, 32'h0);
    check("slave byte", q, 32'h69);
    apb(1'b0, 8'h10, 32'h0);
    check("slave index", {30'h0, q[7:6]}, 32'h1);
    $display("test slave buffer done");
    conclude();
  end
endmodule
